// *** srxs_chk.sv ***
// Status bank port checker
`timescale 1ns/1ps
`default_nettype none
module srxs_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic avs_read,
	input wire logic avs_waitrequest,
	input wire logic emphasis_in,
	input wire logic nonaudio_in,
	input wire logic nonpcm_detect,
	input wire logic input_absent,
	input wire logic pll_locked,
	input wire logic chstat_checksum_fail,
	input wire logic biphase_parity_err,
	input wire logic [7:0] status_event
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wait_one_a: assert property ($rose(avs_read) |->
		avs_waitrequest ##1 !avs_waitrequest) else $error("wait");
	emph_evt_a: assert property (
		$changed(emphasis_in) |-> ##[1:2] status_event[6]) else $error("emph");
	audio_evt_a: assert property (
		$changed(nonaudio_in) |-> ##[1:2] status_event[5]) else $error("nonaud");
	pre_evt_a: assert property (
		$changed(nonpcm_detect) |-> ##[1:2] status_event[4]) else $error("pre");
	crc_evt_a: assert property (
		chstat_checksum_fail |=> ##[0:1] status_event[3]) else $error("crc");
	absent_evt_a: assert property (
		$changed(input_absent) |-> ##[1:2] status_event[2]) else $error("absent");
	par_evt_a: assert property (
		biphase_parity_err |=> ##[0:1] status_event[1]) else $error("parity");
	lock_evt_a: assert property (
		$changed(pll_locked) |-> ##[1:2] status_event[0]) else $error("lock");
endmodule
bind srxs_status_regs srxs_chk i_chk (.*);
`default_nettype wire

// *** srxs_pkg.sv ***
// Package with register map and field positions of the receiver status bank
package srxs_pkg;
	localparam logic [4:0] ADDR_PC_HIGH = 5'h14;
	localparam logic [4:0] ADDR_PC_LOW = 5'h15;
	localparam logic [4:0] ADDR_PD_HIGH = 5'h16;
	localparam logic [4:0] ADDR_PD_LOW = 5'h17;
	localparam logic [4:0] ADDR_ERR = 5'h18;
	localparam logic [4:0] ADDR_EVENT = 5'h1C;
	localparam int BIT_VALID = 7;
	localparam int BIT_EMPH = 6;
	localparam int BIT_NONAUDIO = 5;
	localparam int BIT_PREAMBLE = 4;
	localparam int BIT_CRC = 3;
	localparam int BIT_ABSENT = 2;
	localparam int BIT_PARITY = 1;
	localparam int BIT_LOCK = 0;
	localparam logic [7:0] ERR_RESET = 8'h00;
	localparam logic [31:0] UNMAPPED_DATA = 32'h00000000;
endpackage

// *** srxs_src.sv ***
// Remote stream source model
`timescale 1ns/1ps
`default_nettype none
module srxs_src (
	input wire logic clk,
	input wire logic reset,
	input wire logic [56:0] d,
	output logic s,
	output logic [56:0] q
);
	logic [1:0] n;
	// Subframe strobe every fourth clock
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			n <= 2'h0;
		end else begin
			n <= n + 2'h1;
		end
	end
	assign s = n == 2'h3;
	assign q = d;
endmodule
`default_nettype wire

// *** srxs_status_regs.sv ***
// Receiver status register bank on an Avalon-MM slave
// Overview of operation
// RULE1: Pc bytes shown while non-PCM, else zero
// RULE2: Pd bytes shown while non-PCM, else zero
// RULE3: Subframe non-audio puts channel B Pc in Pd
// RULE4: Emphasis bit 6; event only on change
// RULE5: Non-audio bit 5; event on audio or type change
// RULE6: Preamble bit 4; event only on change
// RULE7: CRC error bit 3 sticky until read
// RULE8: No-stream bit 2; event only on change
// RULE9: Biphase/parity bit 1 sticky until read
// RULE10: Lock bit 0; event only on change
// RULE11: Bit 7 follows last subframe validity
`timescale 1ns/1ps
`default_nettype none
module srxs_status_regs (
	input wire logic clk,
	input wire logic reset,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic subframe_strobe,
	input wire logic rx_valid_flag,
	input wire logic emphasis_in,
	input wire logic nonaudio_in,
	input wire logic [1:0] nonaudio_type,
	input wire logic nonpcm_detect,
	input wire logic subframe_nonaudio,
	input wire logic [15:0] burst_pc_a,
	input wire logic [15:0] burst_pc_b,
	input wire logic [15:0] burst_pd,
	input wire logic chstat_checksum_fail,
	input wire logic input_absent,
	input wire logic biphase_parity_err,
	input wire logic pll_locked,
	output logic [7:0] status_event
);
	logic [15:0] burst_pc_upper_lower;
	logic [15:0] next_burst_pc_upper_lower;
	logic [15:0] burst_pd_upper_lower;
	logic [15:0] next_burst_pd_upper_lower;
	logic [7:0] err;
	logic [7:0] next_err;
	logic [7:0] event_flags;
	logic [7:0] next_event_flags;
	logic [1:0] type_seen;
	logic [1:0] next_type_seen;
	logic ack;
	logic next_ack;
	logic [31:0] next_readdata;
	logic err_read;
	logic [7:0] live;
	logic [7:0] changed;

	assign err_read = ack && avs_read && avs_address == srxs_pkg::ADDR_ERR;
	assign avs_waitrequest = (avs_read || avs_write) && !ack;
	assign status_event = event_flags;

	always_comb begin
		live = err;
		live[srxs_pkg::BIT_EMPH] = emphasis_in;
		live[srxs_pkg::BIT_NONAUDIO] = nonaudio_in;
		live[srxs_pkg::BIT_PREAMBLE] = nonpcm_detect;
		live[srxs_pkg::BIT_ABSENT] = input_absent;
		live[srxs_pkg::BIT_LOCK] = pll_locked;
		changed = live ^ err;
	end

	always_comb begin
		next_burst_pc_upper_lower = 16'h0000;
		next_burst_pd_upper_lower = 16'h0000;
		if (nonpcm_detect) begin
			next_burst_pc_upper_lower = burst_pc_a; // RULE1
			if (subframe_nonaudio) begin
				next_burst_pd_upper_lower = burst_pc_b; // RULE3
			end else begin
				next_burst_pd_upper_lower = burst_pd; // RULE2
			end
		end
	end

	always_comb begin
		next_err = live;
		next_type_seen = type_seen;
		next_event_flags = event_flags;
		if (subframe_strobe) begin
			next_err[srxs_pkg::BIT_VALID] = rx_valid_flag; // RULE11
		end
		// Sticky bits; a new error beats the read clear
		// Only a reported error is cleared; a later one survives the read
		next_err[srxs_pkg::BIT_CRC] = chstat_checksum_fail ||
			(err[srxs_pkg::BIT_CRC] &&
			!(err_read && avs_readdata[srxs_pkg::BIT_CRC])); // RULE7
		next_err[srxs_pkg::BIT_PARITY] = biphase_parity_err ||
			(err[srxs_pkg::BIT_PARITY] &&
			!(err_read && avs_readdata[srxs_pkg::BIT_PARITY])); // RULE9
		if (err_read) begin
			next_event_flags = 8'h00;
		end
		if (changed[srxs_pkg::BIT_EMPH]) begin
			next_event_flags[srxs_pkg::BIT_EMPH] = 1'b1; // RULE4
		end
		if (changed[srxs_pkg::BIT_NONAUDIO] ||
			(nonaudio_in && nonaudio_type != type_seen)) begin
			next_event_flags[srxs_pkg::BIT_NONAUDIO] = 1'b1; // RULE5
		end
		if (nonaudio_in) begin
			next_type_seen = nonaudio_type;
		end
		if (changed[srxs_pkg::BIT_PREAMBLE]) begin
			next_event_flags[srxs_pkg::BIT_PREAMBLE] = 1'b1; // RULE6
		end
		if (chstat_checksum_fail) begin
			next_event_flags[srxs_pkg::BIT_CRC] = 1'b1; // RULE7
		end
		if (changed[srxs_pkg::BIT_ABSENT]) begin
			next_event_flags[srxs_pkg::BIT_ABSENT] = 1'b1; // RULE8
		end
		if (biphase_parity_err) begin
			next_event_flags[srxs_pkg::BIT_PARITY] = 1'b1; // RULE9
		end
		if (changed[srxs_pkg::BIT_LOCK]) begin
			next_event_flags[srxs_pkg::BIT_LOCK] = 1'b1; // RULE10
		end
		if (subframe_strobe && rx_valid_flag != err[srxs_pkg::BIT_VALID]) begin
			next_event_flags[srxs_pkg::BIT_VALID] = 1'b1; // RULE11
		end
	end

	always_comb begin
		next_ack = (avs_read || avs_write) && !ack;
		next_readdata = avs_readdata;
		if (avs_read && !ack) begin
			case (avs_address)
				srxs_pkg::ADDR_PC_HIGH:
					next_readdata = {24'h000000, burst_pc_upper_lower[15:8]};
				srxs_pkg::ADDR_PC_LOW:
					next_readdata = {24'h000000, burst_pc_upper_lower[7:0]};
				srxs_pkg::ADDR_PD_HIGH:
					next_readdata = {24'h000000, burst_pd_upper_lower[15:8]};
				srxs_pkg::ADDR_PD_LOW:
					next_readdata = {24'h000000, burst_pd_upper_lower[7:0]};
				srxs_pkg::ADDR_ERR:
					next_readdata = {24'h000000, err};
				srxs_pkg::ADDR_EVENT:
					next_readdata = {24'h000000, event_flags};
				default:
					next_readdata = srxs_pkg::UNMAPPED_DATA;
			endcase
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			burst_pc_upper_lower <= 16'h0000;
			burst_pd_upper_lower <= 16'h0000;
			err <= srxs_pkg::ERR_RESET;
			event_flags <= 8'h00;
			type_seen <= 2'h0;
			ack <= 1'b0;
			avs_readdata <= srxs_pkg::UNMAPPED_DATA;
		end else begin
			burst_pc_upper_lower <= next_burst_pc_upper_lower;
			burst_pd_upper_lower <= next_burst_pd_upper_lower;
			err <= next_err;
			event_flags <= next_event_flags;
			type_seen <= next_type_seen;
			ack <= next_ack;
			avs_readdata <= next_readdata;
		end
	end
endmodule
`default_nettype wire

// *** srxs_status_regs_tb_top.sv ***
// Status bank bench
`timescale 1ns/1ps
`default_nettype none
module srxs_status_regs_tb_top;
	logic clk = 0, reset = 1, avs_read = 0, avs_waitrequest, s;
	logic [4:0] avs_address = 5'h00;
	logic [31:0] avs_readdata;
	logic [7:0] status_event;
	logic [56:0] d = 57'h0, q;
	int miscompares = 0, tests_run = 0, pc, pd, st, ev, prev = 0;
	srxs_src i_src (.*);
	srxs_status_regs i_dut (.*, .avs_write(1'b0), .avs_writedata(32'h0),
		.avs_byteenable(4'h0), .nonaudio_type(2'h0), .subframe_strobe(s),
		.rx_valid_flag(q[56]), .emphasis_in(q[55]), .nonaudio_in(q[54]),
		.nonpcm_detect(q[53]), .subframe_nonaudio(q[52]), .input_absent(q[51]),
		.pll_locked(q[50]), .burst_pc_a(q[49:34]), .burst_pc_b(q[33:18]),
		.burst_pd(q[17:2]), .chstat_checksum_fail(q[1]), .biphase_parity_err(q[0]));
	always #20 clk = ~clk;
	task cmp(input int e, input logic [31:0] g);
		tests_run++;
		if (g !== 32'(e)) begin
			miscompares++;
			$display("CHECK FAILED %0t %h %h", $time, 32'(e), g);
		end
	endtask
	task chk(input int e, input logic [4:0] a);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		do @(posedge clk); while (avs_waitrequest !== 1'b0);
		cmp(e, avs_readdata);
		avs_read <= 1'b0;
	endtask
	task tally_and_finish;
		$display("ran %0d bad %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		tally_and_finish;
	end
	initial begin
		void'($urandom(92577));
		repeat (10) @(posedge clk);
		reset <= 1'b0;
		repeat (12) begin
			@(posedge clk) d <= 57'({$urandom, $urandom});
			@(posedge clk) d[1:0] <= 2'h0;
			pc = d[53] ? int'(d[49:34]) : 0;
			pd = d[53] ? int'(d[52] ? d[33:18] : d[17:2]) : 0;
			st = int'({d[56:53], d[1], d[51], d[0], d[50]});
			ev = ((st ^ prev) & 'hF5) | (st & 'h0A);
			prev = st;
			repeat (8) @(posedge clk);
			cmp(ev, 32'(status_event));
			chk(ev, 5'h1C);
			chk(pc >> 8, 5'h14);
			chk(pc & 8'hFF, 5'h15);
			chk(pd >> 8, 5'h16);
			chk(pd & 8'hFF, 5'h17);
			chk(st, 5'h18);
			chk(st & 8'hF5, 5'h18);
			chk(0, 5'h1C);
			chk(0, 5'h00);
		end
		tally_and_finish;
	end
endmodule
`default_nettype wire
